//--- rtl/hub_sideband_control_pins.sv
// Purpose: Sideband pin logic of a hub: Type-C attach, speed, suspend.
// Assumes: Hub core status arrives on clk; pins are asynchronous.
// Notes: Registers reached over AXI4-Lite.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module hub_sideband_control_pins (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pins from the Type-C controller and host.
    input wire logic ext_reset_n,
    input wire logic typec_ctrl_mode_sel,
    input wire logic attach_polarity_sel,
    input wire logic [hub_sideband_pkg::ATTACH_W-1:0] cAttachIn,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] orientation_in,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] orient_a_attach_in,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] orient_b_attach_in,
    // Hub core status.
    input wire logic upLinkConnected,
    input wire logic upLinkSuperSpeed,
    input wire logic usb2Suspended,
    // Pin and core outputs.
    output logic [hub_sideband_pkg::MUX_PORTS-1:0] phyEnA,
    output logic [hub_sideband_pkg::MUX_PORTS-1:0] phyEnB,
    output logic upSpeedOut,
    output logic upSpeedOe,
    output logic suspend_state_out,
    output logic hubResetMode,
    output logic mgmtI2cBridge,
    // AXI4-Lite slave.
    input wire logic [hub_sideband_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hub_sideband_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import hub_sideband_pkg::*;

    localparam int SYNC_W = 3 + ATTACH_W + 3 * MUX_PORTS;

    // ====================================================================
    // Pin synchronisation
    // ====================================================================
    logic [SYNC_W-1:0] pinsSynced;
    logic extRstSync;
    logic modeSync;
    logic polSync;
    logic [ATTACH_W-1:0] cAttSync;
    logic [MUX_PORTS-1:0] abSync;
    logic [MUX_PORTS-1:0] muxASync;
    logic [MUX_PORTS-1:0] muxBSync;

    sync_two_flop #(.WIDTH(SYNC_W)) pinSync (
        .clk(clk),
        .rst_n(rst_n),
        .async({ext_reset_n, typec_ctrl_mode_sel, attach_polarity_sel,
                cAttachIn, orientation_in, orient_a_attach_in,
                orient_b_attach_in}),
        .synced(pinsSynced)
    );
    assign {extRstSync, modeSync, polSync, cAttSync, abSync, muxASync,
            muxBSync} = pinsSynced;

    // ====================================================================
    // Strap latch
    // ====================================================================
    logic strapMode;
    logic strapPol;
    logic extRstPrev;
    logic [1:0] warm;
    logic next_strapMode;
    logic next_strapPol;
    logic [1:0] next_warm;

    always_comb begin
        next_strapMode = strapMode;
        next_strapPol = strapPol;
        next_warm = warm;
        if (warm != STRAP_WAIT) begin
            next_warm = warm + 2'h1;
        end
        if (warm == STRAP_WAIT - 2'h1) begin
            next_strapMode = modeSync;
            next_strapPol = polSync;
        end
        if (extRstSync && !extRstPrev && warm == STRAP_WAIT) begin
            next_strapMode = modeSync;
            next_strapPol = polSync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strapMode <= 1'b0;
            strapPol <= 1'b0;
            warm <= 2'h0;
            extRstPrev <= 1'b0;
        end else begin
            strapMode <= next_strapMode;
            strapPol <= next_strapPol;
            warm <= next_warm;
            extRstPrev <= extRstSync;
        end
    end

    // ====================================================================
    // Attach decode and pin outputs
    // ====================================================================
    logic inReset;
    logic [ATTACH_W-1:0] cAtt;
    logic [MUX_PORTS-1:0] ab;
    logic [MUX_PORTS-1:0] muxA;
    logic [MUX_PORTS-1:0] muxB;
    logic [MUX_PORTS-1:0] next_phyEnA;
    logic [MUX_PORTS-1:0] next_phyEnB;
    logic next_upSpeedOut;
    logic next_upSpeedOe;
    logic next_suspend;
    logic ctrlReg;
    logic next_ctrlReg;

    // Reset mode while external reset low.
    // The cycle of the release edge is kept in reset so that the pin
    // outputs never use straps that are still being relatched.
    assign inReset = !extRstSync || !extRstPrev || warm != STRAP_WAIT;
    assign cAtt = cAttSync ^ {ATTACH_W{strapPol}};
    assign ab = abSync ^ {MUX_PORTS{strapPol}};
    assign muxA = muxASync ^ {MUX_PORTS{strapPol}};
    assign muxB = muxBSync ^ {MUX_PORTS{strapPol}};

    always_comb begin
        next_phyEnA = '0;
        next_phyEnB = '0;
        next_upSpeedOut = 1'b0;
        next_upSpeedOe = 1'b0;
        next_suspend = 1'b0;
        if (!inReset) begin
            if (strapMode) begin
                next_phyEnA = muxA;
                next_phyEnB = muxB;
            end else begin
                next_phyEnA = cAtt[MUX_PORTS-1:0] & ~ab;
                next_phyEnB = cAtt[MUX_PORTS-1:0] & ab;
            end
            next_upSpeedOe = upLinkConnected;
            next_upSpeedOut = upLinkConnected && !upLinkSuperSpeed;
            next_suspend = usb2Suspended;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phyEnA <= '0;
            phyEnB <= '0;
            upSpeedOut <= 1'b0;
            upSpeedOe <= 1'b0;
            suspend_state_out <= 1'b0;
            hubResetMode <= 1'b1;
            mgmtI2cBridge <= CTRL_ROLE_RESET;
        end else begin
            phyEnA <= next_phyEnA;
            phyEnB <= next_phyEnB;
            upSpeedOut <= next_upSpeedOut;
            upSpeedOe <= next_upSpeedOe;
            suspend_state_out <= next_suspend;
            hubResetMode <= inReset;
            mgmtI2cBridge <= next_ctrlReg;
        end
    end

    // ====================================================================
    // AXI4-Lite slave
    // ====================================================================
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic next_awHeld;
    logic next_wHeld;
    logic [ADDR_W-1:0] next_awAddr;
    logic [31:0] next_wData;
    logic [3:0] next_wStrb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] statusWord;
    logic [31:0] attachWord;

    always_comb begin
        statusWord = '0;
        statusWord[STATUS_PHYA_POS +: MUX_PORTS] = phyEnA;
        statusWord[STATUS_PHYB_POS +: MUX_PORTS] = phyEnB;
        statusWord[STATUS_MODE_BIT] = strapMode;
        statusWord[STATUS_POL_BIT] = strapPol;
        statusWord[STATUS_RST_BIT] = hubResetMode;
        statusWord[STATUS_SPDOE_BIT] = upSpeedOe;
        statusWord[STATUS_SPD_BIT] = upSpeedOut;
        statusWord[STATUS_SUSP_BIT] = suspend_state_out;
        attachWord = '0;
        attachWord[ATTACH_C_POS +: ATTACH_W] = cAtt;
        attachWord[ATTACH_AB_POS +: MUX_PORTS] = ab;
        attachWord[ATTACH_MA_POS +: MUX_PORTS] = muxA;
        attachWord[ATTACH_MB_POS +: MUX_PORTS] = muxB;
    end

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_ctrlReg = ctrlReg;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (awHeld && wHeld && !s_axi_bvalid) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            unique case (awAddr)
                CTRL_OFFSET: begin
                    if (wStrb[0]) begin
                        next_ctrlReg = wData[CTRL_ROLE_BIT];
                    end
                end
                STATUS_OFFSET, ATTACH_OFFSET: begin
                    next_bresp = RESP_OKAY;
                end
                default: begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            unique case (s_axi_araddr)
                CTRL_OFFSET: begin
                    next_rdata[CTRL_ROLE_BIT] = ctrlReg;
                end
                STATUS_OFFSET: begin
                    next_rdata = statusWord;
                end
                ATTACH_OFFSET: begin
                    next_rdata = attachWord;
                end
                default: begin
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            wStrb <= '0;
            ctrlReg <= CTRL_ROLE_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            ctrlReg <= next_ctrlReg;
            s_axi_awready <= !next_awHeld && !next_bvalid;
            s_axi_wready <= !next_wHeld && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

//--- rtl/hub_sideband_pkg.sv
// Purpose: Constants for the hub sideband control and status pin block.
// Assumes: One 250 MHz clock, AXI4-Lite register access.
// Notes: Offsets are byte addresses of 32-bit words.
// Summary of operation
// - Mode select low: attach plus orientation inputs.
// - Mode select high: orientation A/B attach inputs.
// - Undriven mode select defaults to mode one.
// - Speed pin: low SuperSpeed, high USB2, else hi-Z.
// - Suspend output follows USB 2.0 suspend state.
// - External reset low holds hub in reset.
// - Management port: SMBus target or I2C bridge.
// - Polarity input high inverts all attach inputs.
// - Mode two attach input gates its SuperSpeed PHY.
// - Straps latched at power-on and reset release.
package hub_sideband_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] ATTACH_OFFSET = 4'h8;
    localparam int CTRL_ROLE_BIT = 0;
    localparam logic CTRL_ROLE_RESET = 1'b0;
    localparam int STATUS_PHYA_POS = 0;
    localparam int STATUS_PHYB_POS = 2;
    localparam int STATUS_MODE_BIT = 4;
    localparam int STATUS_POL_BIT = 5;
    localparam int STATUS_RST_BIT = 6;
    localparam int STATUS_SPDOE_BIT = 7;
    localparam int STATUS_SPD_BIT = 8;
    localparam int STATUS_SUSP_BIT = 9;
    localparam int ATTACH_C_POS = 0;
    localparam int ATTACH_AB_POS = 4;
    localparam int ATTACH_MA_POS = 8;
    localparam int ATTACH_MB_POS = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ATTACH_W = 3;
    localparam int MUX_PORTS = 2;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
endpackage

//--- rtl/sync_two_flop.sv
// Purpose: Two flip-flop synchroniser for a vector of pin levels.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Levels.
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule
`default_nettype wire

//--- bench/hub_sideband_sva.sv
// Purpose: Port checker for the hub sideband pin block.
// Assumes: One clock; rst_n is synchronous and active low.
// Notes: Sees the top module's ports only.
`timescale 1ns/1ps
`default_nettype none
module hub_sideband_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pins and core status.
    input wire logic ext_reset_n,
    input wire logic upLinkConnected,
    input wire logic upLinkSuperSpeed,
    input wire logic usb2Suspended,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] phyEnA,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] phyEnB,
    input wire logic upSpeedOut,
    input wire logic upSpeedOe,
    input wire logic suspend_state_out,
    input wire logic hubResetMode,
    input wire logic mgmtI2cBridge,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import hub_sideband_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Assertions
    a_reset_mode_entry: assert property (
        (!ext_reset_n) [*4] |=> hubResetMode) else $error("reset mode");
    a_reset_pins_idle: assert property (
        hubResetMode |-> {phyEnA, phyEnB} == 4'h0 && !upSpeedOe
        && !suspend_state_out) else $error("pins active in reset");
    a_speed_hiz_idle: assert property (
        !upLinkConnected |=> !upSpeedOe) else $error("speed pin driven");
    a_speed_super_low: assert property (
        upLinkConnected && upLinkSuperSpeed ##1 !hubResetMode
        |-> upSpeedOe && !upSpeedOut) else $error("superspeed level");
    a_speed_usb2_high: assert property (
        upLinkConnected && !upLinkSuperSpeed ##1 !hubResetMode
        |-> upSpeedOe && upSpeedOut) else $error("usb2 level");
    a_suspend_tracks_core: assert property (
        !hubResetMode |-> suspend_state_out == $past(usb2Suspended))
        else $error("suspend level");
    a_role_only_written: assert property (
        !(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready)
        [*3] |=> $stable(mgmtI2cBridge)) else $error("role moved");
    a_write_resp_due: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("no write response");
    a_read_resp_due: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("no read response");
    a_read_data_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_phy_b_on: cover property (phyEnB != 2'h0);
    c_super_link: cover property (upSpeedOe && !upSpeedOut);
endmodule
bind hub_sideband_control_pins hub_sideband_sva u_hub_sideband_sva (.*);
`default_nettype wire

//--- bench/hub_pin_partner.sv
// Purpose: Type-C controller side of the attach and reset pins.
// Assumes: The bench asks for logical attach levels.
// Notes: Pin levels follow the requests at once.
`timescale 1ns/1ps
`default_nettype none
module hub_pin_partner (
    // Logical requests.
    input wire logic holdReset,
    input wire logic wantMode2,
    input wire logic invertPol,
    input wire logic [hub_sideband_pkg::ATTACH_W-1:0] attach,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] orient,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] muxA,
    input wire logic [hub_sideband_pkg::MUX_PORTS-1:0] muxB,
    // Pins toward the hub.
    output logic ext_reset_n,
    output logic typec_ctrl_mode_sel,
    output logic attach_polarity_sel,
    output logic [hub_sideband_pkg::ATTACH_W-1:0] cAttachIn,
    output logic [hub_sideband_pkg::MUX_PORTS-1:0] orientation_in,
    output logic [hub_sideband_pkg::MUX_PORTS-1:0] orient_a_attach_in,
    output logic [hub_sideband_pkg::MUX_PORTS-1:0] orient_b_attach_in
);
    import hub_sideband_pkg::*;
    assign ext_reset_n = !holdReset;
    assign typec_ctrl_mode_sel = wantMode2;
    assign attach_polarity_sel = invertPol;
    assign cAttachIn = attach ^ {ATTACH_W{invertPol}};
    assign orientation_in = orient ^ {MUX_PORTS{invertPol}};
    assign orient_a_attach_in = muxA ^ {MUX_PORTS{invertPol}};
    assign orient_b_attach_in = muxB ^ {MUX_PORTS{invertPol}};
endmodule
`default_nettype wire

//--- bench/hub_sideband_control_pins_test.sv
// Purpose: Self-checking bench for the hub sideband pin block.
// Assumes: The partner model drives all Type-C pins.
// Notes: Straps are relatched by pulsing the external reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
    failCount++; $display("Error at %0t: got %h want %h", $time, g, e); \
    end end
module hub_sideband_control_pins_test;
    import hub_sideband_pkg::*;
    logic clk = 1'b0;
    logic rst_n, holdReset, wantMode2, invertPol, ext_reset_n;
    logic typec_ctrl_mode_sel, attach_polarity_sel;
    logic [2:0] attach, cAttachIn;
    logic [1:0] orient, muxA, muxB, orientation_in;
    logic [1:0] orient_a_attach_in, orient_b_attach_in, phyEnA, phyEnB;
    logic upLinkConnected, upLinkSuperSpeed, usb2Suspended;
    logic upSpeedOut, upSpeedOe, suspend_state_out, hubResetMode;
    logic mgmtI2cBridge, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int failCount = 0;
    int samplesChecked = 0;
    int cycles = 0;
    hub_pin_partner u_hub_pin_partner (.*);
    hub_sideband_control_pins u_hub_sideband_control_pins (.*);
    always #2 clk = ~clk;
    // ==========================================
    // Bus tasks
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
                            input logic [1:0] er);
        bit ad;
        bit wd;
        @(posedge clk);
        ad = 0;
        wd = 0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ad && wd)) begin
            @(posedge clk);
            ad |= s_axi_awready;
            wd |= s_axi_wready;
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid) @(posedge clk);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic axiRead(input logic [3:0] a, input logic [31:0] ed);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, RESP_OKAY)
    endtask
    task automatic results();
        $display("Checked %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            results();
        end
    end
    // ==========================================
    // Test sequence
    initial begin
        rst_n = 1'b0;
        {holdReset, wantMode2, invertPol, attach, orient, muxA} = 10'h0;
        {muxB, upLinkConnected, upLinkSuperSpeed, usb2Suspended} = 5'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 44'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        axiRead(STATUS_OFFSET, 32'h0);
        axiRead(CTRL_OFFSET, 32'h0);
        axiWrite(CTRL_OFFSET, 32'h1, RESP_OKAY);
        repeat (2) @(posedge clk);
        `CHK(mgmtI2cBridge, 1'b1)
        axiWrite(4'hc, 32'h0, RESP_SLVERR);
        axiWrite(STATUS_OFFSET, 32'hffffffff, RESP_OKAY);
        axiRead(CTRL_OFFSET, 32'h1);
        axiWrite(CTRL_OFFSET, 32'h0, RESP_OKAY);
        repeat (2) @(posedge clk);
        `CHK(mgmtI2cBridge, 1'b0)
        for (int i = 0; i < 8; i++) begin
            {upLinkConnected, upLinkSuperSpeed, usb2Suspended} <= i[2:0];
            repeat (3) @(posedge clk);
            `CHK(upSpeedOe, i[2])
            if (i[2]) `CHK(upSpeedOut, !i[1])
            `CHK(suspend_state_out, i[0])
        end
        {upLinkConnected, upLinkSuperSpeed, usb2Suspended} <= 3'h0;
        for (int k = 0; k < 4; k++) begin
            {wantMode2, invertPol} <= k[1:0];
            {attach, orient, muxA, muxB} <= {3'h3, 2'h2, 2'h2, 2'h1};
            holdReset <= 1'b1;
            repeat (6) @(posedge clk);
            `CHK(hubResetMode, 1'b1)
            `CHK({phyEnA, phyEnB}, 4'h0)
            holdReset <= 1'b0;
            repeat (6) @(posedge clk);
            `CHK(hubResetMode, 1'b0)
            `CHK({phyEnA, phyEnB}, k[1] ? 4'h9 : 4'h6)
            axiRead(STATUS_OFFSET,
                    {26'h0, k[0], k[1], k[1] ? 4'h6 : 4'h9});
            axiRead(ATTACH_OFFSET, 32'h1223);
            {attach, muxA} <= 5'h0;
            repeat (6) @(posedge clk);
            `CHK({phyEnA, phyEnB}, k[1] ? 4'h1 : 4'h0)
        end
        wantMode2 <= 1'b0;
        repeat (6) @(posedge clk);
        axiRead(STATUS_OFFSET, 32'h34);
        results();
    end
endmodule
`default_nettype wire
